// ### hdl/gcq_params.svh
// offsets, field positions, reset value and counts for the command word
`ifndef GCQ_PARAMS_SVH
`define GCQ_PARAMS_SVH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define GCQ_CMD_OFS 8'h00
`define GCQ_ADDR_W 8
`define GCQ_DATA_W 32
`define GCQ_CMD_RESET 32'h0000_0200

// ---------------------------------------------------------------
// fields of the command word
// ---------------------------------------------------------------
`define GCQ_TXQ_LSB 24
`define GCQ_TXQ_MSB 27
`define GCQ_CFGQ_BIT 21
`define GCQ_POLL_LSB 10
`define GCQ_POLL_MSB 13
`define GCQ_MASK_BIT 9
`define GCQ_AR_BIT 0
`define GCQ_MASK_RESET 1'b1

// ---------------------------------------------------------------
// channels, queues and descriptors
// ---------------------------------------------------------------
`define GCQ_NUM_CH 4
`define GCQ_NUM_Q 5
`define GCQ_CFGQ_IDX 3'h4
`define GCQ_HOLD_BIT 30
`define GCQ_SETUP_BITS 16

`endif

// ### hdl/gcq_pkg.sv
// types shared by the global command block
package gcq_pkg;

	typedef enum logic [6:0]
	{
		ST_IDLE = 7'h01,
		ST_AR_NEXT = 7'h02,
		ST_AR_BASE = 7'h04,
		ST_AR_LEN = 7'h08,
		ST_AR_DONE = 7'h10,
		ST_POLL_W0 = 7'h20,
		ST_POLL_W1 = 7'h40
	} gcq_state_t;

	typedef enum logic [1:0]
	{
		FK_QBASE = 2'h0,
		FK_QLEN = 2'h1,
		FK_DESC_W0 = 2'h2,
		FK_DESC_W1 = 2'h3
	} gcq_fetch_t;

endpackage : gcq_pkg

// ### hdl/gcq_global_command.sv
// global command word: queue setup, transmit poll and action request
`timescale 1ns/1ps
`include "gcq_params.svh"

module gcq_global_command #(
	parameter int CHANNELS = `GCQ_NUM_CH,
	parameter int DATA_W = `GCQ_DATA_W
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [`GCQ_ADDR_W-1:0] regAddr,
	input wire logic [3:0] regByteEn,
	input wire logic [31:0] regWrData,
	output logic [31:0] regRdData,
	output logic regRdValid,
	input wire logic dmaControlSchemeSelect,
	input wire logic [`GCQ_SETUP_BITS-1:0] perChannelSetupBits,
	input wire logic [3:0] txHoldSeen,
	output logic fetchReq,
	output logic [1:0] fetchKind,
	output logic [2:0] fetchSel,
	input wire logic fetchAck,
	input wire logic [31:0] fetchData,
	output logic queueSetupValid,
	output logic [2:0] queueSetupIdx,
	output logic [31:0] queueSetupBase,
	output logic [31:0] queueSetupLen,
	output logic channelSetupValid,
	output logic [`GCQ_SETUP_BITS-1:0] channelSetupBits,
	output logic requestDoneSet,
	output logic requestFailedSet,
	output logic requestIrqMask,
	output logic [3:0] txHalted,
	output logic [3:0] txAdvance,
	output logic [31:0] txNextDesc
);

	// ---------------------------------------------------------------
	// parameter check
	// ---------------------------------------------------------------
	generate
		if (CHANNELS != `GCQ_NUM_CH || DATA_W != `GCQ_DATA_W)
		begin : g_bad_param
			$error("gcq_global_command: only four channels, 32-bit data");
		end
	endgenerate

	// lowest set bit of a small mask
	function automatic logic [2:0] gcq_lowest(input logic [4:0] v);
		logic [2:0] idx;
		idx = 3'h0;
		for (int i = 4; i >= 0; i--)
		begin
			if (v[i])
			begin
				idx = 3'(i);
			end
		end
		return idx;
	endfunction : gcq_lowest

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	gcq_pkg::gcq_state_t state_reg, state_next;
	logic [3:0] txQueueSetup_reg, txQueueSetup_next;
	logic configQueueSetup_reg, configQueueSetup_next;
	logic [3:0] pollPend_reg, pollPend_next;
	logic irqMask_reg, irqMask_next;
	logic arPend_reg, arPend_next;
	logic [4:0] work_reg, work_next;
	logic [2:0] cur_reg, cur_next;
	logic failed_reg, failed_next;
	logic holdWord_reg, holdWord_next;
	logic [31:0] rdData_reg, rdData_next;
	logic rdValid_reg, rdValid_next;
	logic fetchReq_reg, fetchReq_next;
	logic [1:0] fetchKind_reg, fetchKind_next;
	logic [2:0] fetchSel_reg, fetchSel_next;
	logic qValid_reg, qValid_next;
	logic [2:0] qIdx_reg, qIdx_next;
	logic [31:0] qBase_reg, qBase_next;
	logic [31:0] qLen_reg, qLen_next;
	logic chValid_reg, chValid_next;
	logic [`GCQ_SETUP_BITS-1:0] chBits_reg, chBits_next;
	logic done_reg, done_next;
	logic fail_reg, fail_next;
	logic [3:0] halted_reg, halted_next;
	logic [3:0] advance_reg, advance_next;
	logic [31:0] nextDesc_reg, nextDesc_next;
	logic cmdHit;

	assign cmdHit = (regAddr == `GCQ_CMD_OFS);

	// ---------------------------------------------------------------
	// next-state logic
	// ---------------------------------------------------------------
	always_comb
	begin
		state_next = state_reg;
		txQueueSetup_next = txQueueSetup_reg;
		configQueueSetup_next = configQueueSetup_reg;
		pollPend_next = pollPend_reg;
		irqMask_next = irqMask_reg;
		arPend_next = arPend_reg;
		work_next = work_reg;
		cur_next = cur_reg;
		failed_next = failed_reg;
		holdWord_next = holdWord_reg;
		rdData_next = rdData_reg;
		rdValid_next = 1'b0;
		fetchReq_next = fetchReq_reg;
		fetchKind_next = fetchKind_reg;
		fetchSel_next = fetchSel_reg;
		qValid_next = 1'b0;
		qIdx_next = qIdx_reg;
		qBase_next = qBase_reg;
		qLen_next = qLen_reg;
		chValid_next = 1'b0;
		chBits_next = chBits_reg;
		done_next = 1'b0;
		fail_next = 1'b0;
		halted_next = halted_reg;
		advance_next = 4'h0;
		nextDesc_next = nextDesc_reg;

		unique case (state_reg)
			gcq_pkg::ST_IDLE:
			begin
				if (arPend_reg)
				begin
					arPend_next = 1'b0;
					// snapshot of flags; clear ones are skipped
					work_next = {configQueueSetup_reg, txQueueSetup_reg};
					chValid_next = 1'b1;
					chBits_next = perChannelSetupBits;
					failed_next = 1'b0;
					state_next = gcq_pkg::ST_AR_NEXT;
				end
				else if (pollPend_reg != 4'h0)
				begin
					cur_next = gcq_lowest({1'b0, pollPend_reg});
					pollPend_next[cur_next[1:0]] = 1'b0;
					fetchReq_next = 1'b1;
					fetchKind_next = gcq_pkg::FK_DESC_W0;
					fetchSel_next = cur_next;
					state_next = gcq_pkg::ST_POLL_W0;
				end
			end
			gcq_pkg::ST_AR_NEXT:
			begin
				if (work_reg == 5'h00)
				begin
					state_next = gcq_pkg::ST_AR_DONE;
				end
				else
				begin
					cur_next = gcq_lowest(work_reg);
					fetchReq_next = 1'b1;
					fetchKind_next = gcq_pkg::FK_QBASE;
					fetchSel_next = cur_next;
					state_next = gcq_pkg::ST_AR_BASE;
				end
			end
			gcq_pkg::ST_AR_BASE:
			begin
				if (fetchAck)
				begin
					qBase_next = fetchData;
					fetchKind_next = gcq_pkg::FK_QLEN;
					state_next = gcq_pkg::ST_AR_LEN;
				end
			end
			gcq_pkg::ST_AR_LEN:
			begin
				if (fetchAck)
				begin
					fetchReq_next = 1'b0;
					work_next[cur_reg] = 1'b0;
					// an empty queue cannot be placed
					if (fetchData == 32'h0000_0000)
					begin
						failed_next = 1'b1;
					end
					else
					begin
						qLen_next = fetchData;
						qIdx_next = cur_reg;
						qValid_next = 1'b1;
					end
					state_next = gcq_pkg::ST_AR_NEXT;
				end
			end
			gcq_pkg::ST_AR_DONE:
			begin
				done_next = ~failed_reg;
				fail_next = failed_reg;
				state_next = gcq_pkg::ST_IDLE;
			end
			gcq_pkg::ST_POLL_W0:
			begin
				if (fetchAck)
				begin
					holdWord_next = fetchData[`GCQ_HOLD_BIT];
					fetchKind_next = gcq_pkg::FK_DESC_W1;
					state_next = gcq_pkg::ST_POLL_W1;
				end
			end
			gcq_pkg::ST_POLL_W1:
			begin
				if (fetchAck)
				begin
					fetchReq_next = 1'b0;
					if (!holdWord_reg)
					begin
						nextDesc_next = fetchData;
						advance_next[cur_reg[1:0]] = 1'b1;
						halted_next[cur_reg[1:0]] = 1'b0;
					end
					state_next = gcq_pkg::ST_IDLE;
				end
			end
		endcase

		// hold seen by the walker; set wins over release
		for (int c = 0; c < `GCQ_NUM_CH; c++)
		begin
			if (txHoldSeen[c] && !dmaControlSchemeSelect)
			begin
				halted_next[c] = 1'b1;
			end
		end

		// register writes; a new request wins over its capture
		if (regWrite && cmdHit)
		begin
			if (regByteEn[3])
			begin
				txQueueSetup_next =
					regWrData[`GCQ_TXQ_MSB:`GCQ_TXQ_LSB];
			end
			if (regByteEn[2])
			begin
				configQueueSetup_next = regWrData[`GCQ_CFGQ_BIT];
			end
			if (regByteEn[1])
			begin
				irqMask_next = regWrData[`GCQ_MASK_BIT];
				for (int c = 0; c < `GCQ_NUM_CH; c++)
				begin
					// only in hold mode and only while halted
					if (regWrData[`GCQ_POLL_LSB + c] && !dmaControlSchemeSelect
						&& halted_reg[c])
					begin
						pollPend_next[c] = 1'b1;
					end
				end
			end
			if (regByteEn[0] && regWrData[`GCQ_AR_BIT])
			begin
				arPend_next = 1'b1;
			end
		end

		// reads; unused bits and other offsets give zero
		if (regRead)
		begin
			rdValid_next = 1'b1;
			rdData_next = 32'h0000_0000;
			if (cmdHit)
			begin
				rdData_next[`GCQ_TXQ_MSB:`GCQ_TXQ_LSB] = txQueueSetup_reg;
				rdData_next[`GCQ_CFGQ_BIT] = configQueueSetup_reg;
				rdData_next[`GCQ_POLL_MSB:`GCQ_POLL_LSB] = pollPend_reg;
				rdData_next[`GCQ_MASK_BIT] = irqMask_reg;
				rdData_next[`GCQ_AR_BIT] = arPend_reg;
			end
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_reg <= gcq_pkg::ST_IDLE;
			txQueueSetup_reg <= 4'h0;
			configQueueSetup_reg <= 1'b0;
			pollPend_reg <= 4'h0;
			irqMask_reg <= `GCQ_MASK_RESET;
			arPend_reg <= 1'b0;
			work_reg <= 5'h00;
			cur_reg <= 3'h0;
			failed_reg <= 1'b0;
			holdWord_reg <= 1'b0;
			rdData_reg <= 32'h0000_0000;
			rdValid_reg <= 1'b0;
			fetchReq_reg <= 1'b0;
			fetchKind_reg <= 2'h0;
			fetchSel_reg <= 3'h0;
			qValid_reg <= 1'b0;
			qIdx_reg <= 3'h0;
			qBase_reg <= 32'h0000_0000;
			qLen_reg <= 32'h0000_0000;
			chValid_reg <= 1'b0;
			chBits_reg <= 16'h0000;
			done_reg <= 1'b0;
			fail_reg <= 1'b0;
			halted_reg <= 4'h0;
			advance_reg <= 4'h0;
			nextDesc_reg <= 32'h0000_0000;
		end
		else
		begin
			state_reg <= state_next;
			txQueueSetup_reg <= txQueueSetup_next;
			configQueueSetup_reg <= configQueueSetup_next;
			pollPend_reg <= pollPend_next;
			irqMask_reg <= irqMask_next;
			arPend_reg <= arPend_next;
			work_reg <= work_next;
			cur_reg <= cur_next;
			failed_reg <= failed_next;
			holdWord_reg <= holdWord_next;
			rdData_reg <= rdData_next;
			rdValid_reg <= rdValid_next;
			fetchReq_reg <= fetchReq_next;
			fetchKind_reg <= fetchKind_next;
			fetchSel_reg <= fetchSel_next;
			qValid_reg <= qValid_next;
			qIdx_reg <= qIdx_next;
			qBase_reg <= qBase_next;
			qLen_reg <= qLen_next;
			chValid_reg <= chValid_next;
			chBits_reg <= chBits_next;
			done_reg <= done_next;
			fail_reg <= fail_next;
			halted_reg <= halted_next;
			advance_reg <= advance_next;
			nextDesc_reg <= nextDesc_next;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign regRdData = rdData_reg;
	assign regRdValid = rdValid_reg;
	assign fetchReq = fetchReq_reg;
	assign fetchKind = fetchKind_reg;
	assign fetchSel = fetchSel_reg;
	assign queueSetupValid = qValid_reg;
	assign queueSetupIdx = qIdx_reg;
	assign queueSetupBase = qBase_reg;
	assign queueSetupLen = qLen_reg;
	assign channelSetupValid = chValid_reg;
	assign channelSetupBits = chBits_reg;
	assign requestDoneSet = done_reg;
	assign requestFailedSet = fail_reg;
	assign requestIrqMask = irqMask_reg;
	assign txHalted = halted_reg;
	assign txAdvance = advance_reg;
	assign txNextDesc = nextDesc_reg;

endmodule : gcq_global_command

// ### bench/gcq_global_command_sva.sv
// checker for the global command word
`timescale 1ns/1ps
module gcq_global_command_sva (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regAddr,
	input wire logic [3:0] regByteEn,
	input wire logic [31:0] regWrData,
	input wire logic regRdValid,
	input wire logic dmaControlSchemeSelect,
	input wire logic [3:0] txHoldSeen,
	input wire logic fetchReq,
	input wire logic [1:0] fetchKind,
	input wire logic [2:0] fetchSel,
	input wire logic fetchAck,
	input wire logic queueSetupValid,
	input wire logic channelSetupValid,
	input wire logic requestDoneSet,
	input wire logic requestFailedSet,
	input wire logic requestIrqMask,
	input wire logic [3:0] txHalted,
	input wire logic [3:0] txAdvance
);
	// ------
	// properties
	// ------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	property p_rd_valid;
		regRead |=> regRdValid;
	endproperty
	a_rd_valid: assert property (p_rd_valid) else $error("no read data");
	property p_mask;
		regWrite && regAddr == 8'h00 && regByteEn[1]
			|=> requestIrqMask == $past(regWrData[9]);
	endproperty
	a_mask: assert property (p_mask) else $error("mask not stored");
	property p_halt;
		|txHoldSeen && !dmaControlSchemeSelect
			|=> (txHalted & $past(txHoldSeen)) == $past(txHoldSeen);
	endproperty
	a_halt: assert property (p_halt) else $error("no halt on hold");
	property p_stay;
		!fetchReq |=> (txHalted & $past(txHalted)) == $past(txHalted);
	endproperty
	a_stay: assert property (p_stay) else $error("halt lost");
	property p_adv_halted;
		|txAdvance |-> ($past(txHalted) & txAdvance) == txAdvance;
	endproperty
	a_adv_halted: assert property (p_adv_halted) else $error("bad advance");
	property p_adv_clear;
		|txAdvance |-> (txHalted & txAdvance) == 4'h0;
	endproperty
	a_adv_clear: assert property (p_adv_clear) else $error("still halted");
	property p_setup;
		queueSetupValid |-> $past(fetchAck) && $past(fetchKind) == 2'h1;
	endproperty
	a_setup: assert property (p_setup) else $error("setup w/o length");
	property p_fetch_hold;
		fetchReq && !fetchAck
			|=> fetchReq && $stable(fetchKind) && $stable(fetchSel);
	endproperty
	a_fetch_hold: assert property (p_fetch_hold) else $error("fetch moved");
	property p_ar_end;
		channelSetupValid |-> ##[1:200] (requestDoneSet || requestFailedSet);
	endproperty
	a_ar_end: assert property (p_ar_end) else $error("request hung");
	property p_one_result;
		!(requestDoneSet && requestFailedSet);
	endproperty
	a_one_result: assert property (p_one_result) else $error("two results");
endmodule : gcq_global_command_sva

bind gcq_global_command gcq_global_command_sva chk_u (.core_clk, .nrst,
	.regWrite, .regRead, .regAddr, .regByteEn, .regWrData, .regRdValid,
	.dmaControlSchemeSelect,
	.txHoldSeen, .fetchReq, .fetchKind, .fetchSel, .fetchAck,
	.queueSetupValid, .channelSetupValid, .requestDoneSet,
	.requestFailedSet, .requestIrqMask, .txHalted, .txAdvance);

// ### bench/gcq_host_mem.sv
// host memory model answering queue and descriptor fetches
`timescale 1ns/1ps
module gcq_host_mem (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic fetchReq,
	input wire logic [1:0] fetchKind,
	input wire logic [2:0] fetchSel,
	input wire logic slow,
	input wire logic holdBit,
	input wire logic [2:0] badQ,
	output logic fetchAck,
	output logic [31:0] fetchData
);
	// ------
	// preloaded tables and answer timing
	// ------
	logic [1:0] waitCnt;
	logic [31:0] word;
	always_comb
	begin
		case (fetchKind)
			2'h0: word = 32'h1000_0000 + {21'h0, fetchSel, 8'h00};
			2'h1: word = (fetchSel == badQ) ? 32'h0 : {29'h0, fetchSel} + 32'h40;
			2'h2: word = {1'b0, holdBit, 30'h5};
			default: word = 32'h2000_0000 + {25'h0, fetchSel, 4'h0};
		endcase
	end
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			fetchAck <= 1'b0;
			waitCnt <= 2'h0;
			fetchData <= 32'h0;
		end
		else if (fetchReq && !fetchAck && waitCnt >= (slow ? 2'h3 : 2'h0))
		begin
			fetchAck <= 1'b1;
			waitCnt <= 2'h0;
			fetchData <= word;
		end
		else
		begin
			fetchAck <= 1'b0;
			waitCnt <= fetchReq ? waitCnt + 2'h1 : 2'h0;
			fetchData <= ~fetchData;
		end
	end
endmodule : gcq_host_mem

// ### bench/gcq_global_command_tb.sv
// self-checking bench for the global command word
`timescale 1ns/1ps
module gcq_global_command_tb;
	logic core_clk, nrst, regWrite, regRead, regRdValid, sel, slow, holdBit;
	logic fetchReq, fetchAck, queueSetupValid, channelSetupValid, fail;
	logic requestDoneSet, requestFailedSet, requestIrqMask;
	logic [7:0] regAddr;
	logic [3:0] regByteEn, txHoldSeen, txHalted, txAdvance;
	logic [31:0] regWrData, regRdData, fetchData, queueSetupBase;
	logic [31:0] queueSetupLen, txNextDesc, d;
	logic [15:0] perChannelSetupBits, channelSetupBits, p;
	logic [1:0] fetchKind;
	logic [2:0] fetchSel, queueSetupIdx, badQ;
	logic [4:0] f;
	logic [71:0] rdQ[$], setQ[$], resQ[$], chsQ[$], advQ[$];
	int n_errors, total_checks, cyc, i, q, c;
	gcq_global_command dut_u (.core_clk, .nrst, .regWrite, .regRead,
		.regAddr, .regByteEn, .regWrData, .regRdData, .regRdValid,
		.dmaControlSchemeSelect(sel), .perChannelSetupBits, .txHoldSeen,
		.fetchReq, .fetchKind, .fetchSel, .fetchAck, .fetchData,
		.queueSetupValid, .queueSetupIdx, .queueSetupBase, .queueSetupLen,
		.channelSetupValid, .channelSetupBits, .requestDoneSet,
		.requestFailedSet, .requestIrqMask, .txHalted, .txAdvance, .txNextDesc);
	gcq_host_mem mem_u (.core_clk, .nrst, .fetchReq, .fetchKind, .fetchSel,
		.slow, .holdBit, .badQ, .fetchAck, .fetchData);
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// ------
	// checking and bus tasks
	// ------
	task automatic chk(input logic [71:0] got, input logic [71:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task test_done;
		n_errors += rdQ.size() + setQ.size() + resQ.size() + advQ.size()
			+ chsQ.size();
		$display("errors=%0d checks=%0d", n_errors, total_checks);
		if (n_errors == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done
	task wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] v);
		regWrite <= 1'b1;
		regAddr <= a;
		regByteEn <= be;
		regWrData <= v;
		@(posedge core_clk);
		regWrite <= 1'b0;
		@(posedge core_clk);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] exp);
		regRead <= 1'b1;
		regAddr <= a;
		rdQ.push_back(exp);
		@(posedge core_clk);
		regRead <= 1'b0;
		@(posedge core_clk);
	endtask : rd
	task poll(input int ch);
		wr(8'h00, 4'h2, 32'h1 << (10 + ch));
		repeat (20) @(posedge core_clk);
	endtask : poll
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_errors++;
			test_done();
		end
		if (regRdValid)
			chk(regRdData, rdQ.pop_front());
		if (queueSetupValid)
			chk({queueSetupIdx, queueSetupBase, queueSetupLen}, setQ.pop_front());
		if (requestDoneSet | requestFailedSet)
			chk({requestFailedSet, requestDoneSet}, resQ.pop_front());
		if (channelSetupValid)
			chk(channelSetupBits, chsQ.pop_front());
		if (|txAdvance)
			chk({txAdvance, txNextDesc}, advQ.pop_front());
	end
	// ------
	// main sequence
	// ------
	initial
	begin
		{nrst, regWrite, regRead, regAddr, regByteEn, regWrData} = '0;
		{txHoldSeen, slow, perChannelSetupBits} = '0;
		// hold mode, hold bit clear, no failing queue
		{sel, holdBit, badQ} = 5'h07;
		d = $urandom(92280);
		repeat (20) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		chk(requestIrqMask, 1'b1);
		rd(8'h00, 32'h0000_0200);
		for (i = 0; i < 6; i++)
		begin
			d = $urandom & ~32'h0000_3c01;
			wr(8'h00, 4'hf, d);
			rd(8'h00, d & 32'h0f20_0200);
		end
		wr(8'h04, 4'hf, 32'hffff_ffff);
		rd(8'h04, 32'h0);
		wr(8'h00, 4'h2, 32'h0);
		rd(8'h00, d & 32'h0f20_0000);
		for (i = 0; i < 8; i++)
		begin
			// second request always meets a failing queue, slow answers
			f = (i == 0) ? 5'h00 : (i == 1) ? 5'h11 : 5'($urandom);
			p = 16'($urandom);
			badQ <= (i == 1) ? 3'h0 : 3'($urandom);
			slow <= (i == 1) ? 1'b1 : 1'($urandom);
			perChannelSetupBits <= p;
			@(posedge core_clk);
			chsQ.push_back(p);
			fail = 1'b0;
			for (q = 0; q < 5; q++)
				if (f[q] && q == badQ)
					fail = 1'b1;
				else if (f[q])
					setQ.push_back({q[2:0], 32'h1000_0000 + (q << 8), 32'h40 + q});
			resQ.push_back(fail ? 2'h2 : 2'h1);
			wr(8'h00, 4'hf, {4'h0, f[3:0], 2'h0, f[4], 21'h1});
			wait (resQ.size() == 0);
			@(posedge core_clk);
			rd(8'h00, {4'h0, f[3:0], 2'h0, f[4], 21'h0});
		end
		for (c = 0; c < 4; c++)
		begin
			poll(c);
			chk(txHalted, 4'h0);
			txHoldSeen <= 4'h1 << c;
			@(posedge core_clk);
			txHoldSeen <= 4'h0;
			@(posedge core_clk);
			chk(txHalted, 4'h1 << c);
			sel <= 1'b1;
			poll(c);
			chk(txHalted, 4'h1 << c);
			sel <= 1'b0;
			holdBit <= 1'b1;
			poll(c);
			chk(txHalted, 4'h1 << c);
			holdBit <= 1'b0;
			advQ.push_back({4'h1 << c, 32'h2000_0000 + c * 16});
			poll(c);
			chk(txHalted, 4'h0);
		end
		test_done();
	end
endmodule : gcq_global_command_tb
